// File: logic/scan_controller.sv
/*
 * Test controller for the analog scan cells: AXI4-Lite registers, test clock divider
 * and the capture, shift and update sequence.
 * Assumes AXI4-Lite inputs are synchronous to MCLK.
 */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`default_nettype none

module scan_controller
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// AXI4-Lite write
	input wire logic [3:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [3:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Test link
	scan_link_if.controller_end LINK
);
	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic aw_have;
		logic w_have;
		logic [3:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic go_pending;
		logic extest;
		logic link_reset;
		logic busy;
		logic done;
		logic [22:0] tx;
		logic [22:0] rx;
		scan_pkg::step_t step;
		logic [4:0] bitn;
		logic [3:0] div;
		logic tck;
		logic link_rst_n;
		logic capture;
		logic shift;
		logic update;
		logic link_extest;
		logic tdi;
	} ctrl_state_t;

	ctrl_state_t q;
	ctrl_state_t d;
	logic [31:0] m;

	function automatic logic [31:0] write_mask(input logic [3:0] strb);
		logic [31:0] r;
		r = '0;
		for (int b = 0; b < 4; b++)
		begin
			r[b * 8 +: 8] = {8{strb[b]}};
		end
		return r;
	endfunction

	assign AWREADY = q.awready;
	assign WREADY = q.wready;
	assign BRESP = q.bresp;
	assign BVALID = q.bvalid;
	assign ARREADY = q.arready;
	assign RDATA = q.rdata;
	assign RRESP = q.rresp;
	assign RVALID = q.rvalid;
	assign LINK.tck = q.tck;
	assign LINK.link_rst_n = q.link_rst_n;
	assign LINK.capture = q.capture;
	assign LINK.shift = q.shift;
	assign LINK.update = q.update;
	assign LINK.extest = q.link_extest;
	assign LINK.tdi = q.tdi;

	always_comb
	begin
		m = write_mask(q.wstrb);
		d = q;
		if (AWVALID && q.awready)
		begin
			d.aw_have = 1'b1;
			d.awaddr = AWADDR;
		end
		if (WVALID && q.wready)
		begin
			d.w_have = 1'b1;
			d.wdata = WDATA;
			d.wstrb = WSTRB;
		end
		if (q.bvalid && BREADY)
		begin
			d.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid)
		begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = scan_pkg::RESP_OKAY;
			case (q.awaddr)
				scan_pkg::ADDR_CTRL:
				begin
					if (m[0])
					begin
						if (q.wdata[scan_pkg::CTRL_GO] && !q.busy)
						begin
							d.go_pending = 1'b1;
							d.busy = 1'b1;
						end
						d.extest = q.wdata[scan_pkg::CTRL_EXTEST];
						d.link_reset = q.wdata[scan_pkg::CTRL_LINK_RESET];
					end
				end
				scan_pkg::ADDR_TX:
				begin
					d.tx = (q.tx & ~m[22:0]) | (q.wdata[22:0] & m[22:0]);
				end
				scan_pkg::ADDR_STATUS:
				begin
					if (m[0] && q.wdata[scan_pkg::STAT_DONE])
					begin
						d.done = 1'b0;
					end
				end
				scan_pkg::ADDR_RX:
				begin
				end
				default:
				begin
					d.bresp = scan_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (q.rvalid && RREADY)
		begin
			d.rvalid = 1'b0;
		end
		if (ARVALID && q.arready)
		begin
			d.rvalid = 1'b1;
			d.rdata = '0;
			d.rresp = scan_pkg::RESP_OKAY;
			case (ARADDR)
				scan_pkg::ADDR_CTRL:
				begin
					d.rdata[scan_pkg::CTRL_EXTEST] = q.extest;
					d.rdata[scan_pkg::CTRL_LINK_RESET] = q.link_reset;
				end
				scan_pkg::ADDR_TX:
				begin
					d.rdata[22:0] = q.tx;
				end
				scan_pkg::ADDR_RX:
				begin
					d.rdata[22:0] = q.rx;
				end
				scan_pkg::ADDR_STATUS:
				begin
					d.rdata[scan_pkg::STAT_BUSY] = q.busy;
					d.rdata[scan_pkg::STAT_DONE] = q.done;
				end
				default:
				begin
					d.rresp = scan_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (q.div == scan_pkg::HALF_LAST)
		begin
			d.div = '0;
			d.tck = !q.tck;
			if (!q.tck)
			begin
				if (q.step == scan_pkg::ST_SHIFT)
				begin
					d.rx[q.bitn] = LINK.tdo;
				end
			end
			else
			begin
				d.link_rst_n = !q.link_reset;
				d.link_extest = q.extest;
				unique case (q.step)
					scan_pkg::ST_IDLE:
					begin
						if (q.go_pending)
						begin
							d.go_pending = 1'b0;
							d.capture = 1'b1;
							d.step = scan_pkg::ST_CAPTURE;
						end
					end
					scan_pkg::ST_CAPTURE:
					begin
						d.capture = 1'b0;
						d.shift = 1'b1;
						d.tdi = q.tx[0];
						d.bitn = '0;
						d.step = scan_pkg::ST_SHIFT;
					end
					scan_pkg::ST_SHIFT:
					begin
						if (q.bitn == scan_pkg::LAST_BIT)
						begin
							d.shift = 1'b0;
							d.update = 1'b1;
							d.step = scan_pkg::ST_UPDATE;
						end
						else
						begin
							d.bitn = q.bitn + 5'h1;
							d.tdi = q.tx[q.bitn + 5'h1];
						end
					end
					scan_pkg::ST_UPDATE:
					begin
						d.update = 1'b0;
						d.step = scan_pkg::ST_IDLE;
						d.busy = 1'b0;
						d.done = 1'b1;
					end
				endcase
			end
		end
		else
		begin
			d.div = q.div + 4'h1;
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		d.arready = !d.rvalid;
		if (!RSTN)
		begin
			d = '0;
			d.tx = scan_pkg::IDLE_PATTERN;
			d.step = scan_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge MCLK)
	begin
		q <= d;
	end
endmodule

`default_nettype wire

// File: logic/scan_pkg.sv
/*
 * Shared constants for the analog boundary-scan cells and their test controller:
 * chain layout, idle pattern, controller register map and link timing.
 * Assumes a 100 MHz controller clock.
 */
`default_nettype none

package scan_pkg;
	localparam int CELLS = 23;
	localparam int DAC_BITS = 10;
	localparam int CELL_COMPARATOR_OFF = 0;
	localparam int CELL_COMPARATOR_RESULT = 1;
	localparam int CELL_COMPARATOR_MUX_SOURCE_SELECT = 2;
	localparam int CELL_COMPARATOR_BANDGAP_ENABLE = 3;
	localparam int CELL_CONVERTER_RESULT = 4;
	localparam int CELL_AMP_CLOCK = 5;
	localparam int CELL_AMP_PATH_ENABLE = 6;
	localparam int CELL_CONVERTER_BANDGAP_ENABLE = 7;
	localparam int CELL_CONVERTER_POWER_ON = 8;
	localparam int CELL_AMP_POWER_ON = 9;
	localparam int CELL_DAC_LSB = 10;
	localparam int CELL_CHANNEL_BYPASS_SELECT = 20;
	localparam int CELL_NEGATIVE_GROUND_ENABLE = 21;
	localparam int CELL_SAMPLE_HOLD = 22;
	localparam logic [22:0] IDLE_PATTERN = 23'h580001;
	localparam logic [4:0] LAST_BIT = 5'h16;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TX = 4'h4;
	localparam logic [3:0] ADDR_RX = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam int CTRL_GO = 0;
	localparam int CTRL_EXTEST = 1;
	localparam int CTRL_LINK_RESET = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int MCLK_NS = 10;
	localparam int TCK_HALF_NS = 20;
	localparam int TCK_HALF_CYC = (TCK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
	localparam logic [3:0] HALF_LAST = 4'(TCK_HALF_CYC - 1);

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_CAPTURE = 4'h2,
		ST_SHIFT = 4'h4,
		ST_UPDATE = 4'h8
	} step_t;
endpackage

`default_nettype wire

// File: logic/scan_link_if.sv
/*
 * Link between the test controller and the analog scan cells.
 * Assumes the controller makes the test clock and changes all strobes on its falling edge.
 */
`default_nettype none

interface scan_link_if;
	logic tck;
	logic link_rst_n;
	logic capture;
	logic shift;
	logic update;
	logic extest;
	logic tdi;
	logic tdo;

	modport device_end (input tck, link_rst_n, capture, shift, update, extest, tdi, output tdo);
	modport controller_end (output tck, link_rst_n, capture, shift, update, extest, tdi,
		input tdo);
endinterface

`default_nettype wire

// File: logic/analog_scan_cells.sv
/*
 * Boundary-scan cells on the digital/analog interface of the comparator and the converter.
 * Assumes the link strobes are stable at each rising test clock edge and that the
 * functional and analog inputs come from other clock domains.
 */
`default_nettype none

// Overview of operation
// - Scan cell on every comparator signal.
// - Scan cell on every converter signal.
// - Comparator off powers comparator down; idle high.
// - Comparator result captured, reads low when idle.
// - Mux source select picks converter mux; idle low.
// - Controller may skip analog units in connectivity tests.
// - Amplifier path enable idles low.
// - Converter power on idles low.
// - Amplifier power on idles low.
// - Code MSB idles high.
// - Code bits eight to zero idle low.
// - Channel bypass select idles high.
// - Negative ground enable idles low.
// - Chains shift least significant bit first.
// - External test applies updated chain contents.
// - Sample hold idles high.
module analog_scan_cells
(
	// Test link
	scan_link_if.device_end LINK,
	// Functional values from the digital logic
	input wire logic FN_COMPARATOR_OFF,
	input wire logic FN_COMPARATOR_MUX_SOURCE_SELECT,
	input wire logic FN_COMPARATOR_BANDGAP_ENABLE,
	input wire logic FN_AMP_CLOCK,
	input wire logic FN_AMP_PATH_ENABLE,
	input wire logic FN_CONVERTER_BANDGAP_ENABLE,
	input wire logic FN_CONVERTER_POWER_ON,
	input wire logic FN_AMP_POWER_ON,
	input wire logic [9:0] FN_DAC_CODE,
	input wire logic FN_CHANNEL_BYPASS_SELECT,
	input wire logic FN_NEGATIVE_GROUND_ENABLE,
	input wire logic FN_SAMPLE_HOLD,
	// Results from the analog circuitry
	input wire logic AN_COMPARATOR_RESULT,
	input wire logic AN_CONVERTER_RESULT,
	// Controls toward the analog circuitry
	output logic COMPARATOR_OFF,
	output logic COMPARATOR_MUX_SOURCE_SELECT,
	output logic COMPARATOR_BANDGAP_ENABLE,
	output logic AMP_CLOCK,
	output logic AMP_PATH_ENABLE,
	output logic CONVERTER_BANDGAP_ENABLE,
	output logic CONVERTER_POWER_ON,
	output logic AMP_POWER_ON,
	output logic [9:0] DAC_CODE,
	output logic CHANNEL_BYPASS_SELECT,
	output logic NEGATIVE_GROUND_ENABLE,
	output logic SAMPLE_HOLD,
	// Results toward the digital logic
	output logic COMPARATOR_RESULT,
	output logic CONVERTER_RESULT
);
	typedef struct packed
	{
		logic [22:0] s1;
		logic [22:0] s2;
		logic [22:0] s3;
		logic [22:0] filt;
		logic [22:0] chain;
		logic [22:0] upd;
		logic [22:0] drive;
		logic tdo;
	} cell_state_t;

	cell_state_t q;
	cell_state_t d;
	logic [22:0] from_side;

	// Every interface signal enters the chain at its own cell.
	assign from_side[scan_pkg::CELL_COMPARATOR_OFF] = FN_COMPARATOR_OFF;
	assign from_side[scan_pkg::CELL_COMPARATOR_RESULT] = AN_COMPARATOR_RESULT;
	assign from_side[scan_pkg::CELL_COMPARATOR_MUX_SOURCE_SELECT] =
		FN_COMPARATOR_MUX_SOURCE_SELECT;
	assign from_side[scan_pkg::CELL_COMPARATOR_BANDGAP_ENABLE] =
		FN_COMPARATOR_BANDGAP_ENABLE;
	assign from_side[scan_pkg::CELL_CONVERTER_RESULT] = AN_CONVERTER_RESULT;
	assign from_side[scan_pkg::CELL_AMP_CLOCK] = FN_AMP_CLOCK;
	assign from_side[scan_pkg::CELL_AMP_PATH_ENABLE] = FN_AMP_PATH_ENABLE;
	assign from_side[scan_pkg::CELL_CONVERTER_BANDGAP_ENABLE] =
		FN_CONVERTER_BANDGAP_ENABLE;
	assign from_side[scan_pkg::CELL_CONVERTER_POWER_ON] = FN_CONVERTER_POWER_ON;
	assign from_side[scan_pkg::CELL_AMP_POWER_ON] = FN_AMP_POWER_ON;
	assign from_side[scan_pkg::CELL_DAC_LSB +: scan_pkg::DAC_BITS] = FN_DAC_CODE;
	assign from_side[scan_pkg::CELL_CHANNEL_BYPASS_SELECT] = FN_CHANNEL_BYPASS_SELECT;
	assign from_side[scan_pkg::CELL_NEGATIVE_GROUND_ENABLE] = FN_NEGATIVE_GROUND_ENABLE;
	assign from_side[scan_pkg::CELL_SAMPLE_HOLD] = FN_SAMPLE_HOLD;

	assign COMPARATOR_OFF = q.drive[scan_pkg::CELL_COMPARATOR_OFF];
	assign COMPARATOR_RESULT = q.drive[scan_pkg::CELL_COMPARATOR_RESULT];
	assign COMPARATOR_MUX_SOURCE_SELECT = q.drive[scan_pkg::CELL_COMPARATOR_MUX_SOURCE_SELECT];
	assign COMPARATOR_BANDGAP_ENABLE = q.drive[scan_pkg::CELL_COMPARATOR_BANDGAP_ENABLE];
	assign CONVERTER_RESULT = q.drive[scan_pkg::CELL_CONVERTER_RESULT];
	assign AMP_CLOCK = q.drive[scan_pkg::CELL_AMP_CLOCK];
	assign AMP_PATH_ENABLE = q.drive[scan_pkg::CELL_AMP_PATH_ENABLE];
	assign CONVERTER_BANDGAP_ENABLE = q.drive[scan_pkg::CELL_CONVERTER_BANDGAP_ENABLE];
	assign CONVERTER_POWER_ON = q.drive[scan_pkg::CELL_CONVERTER_POWER_ON];
	assign AMP_POWER_ON = q.drive[scan_pkg::CELL_AMP_POWER_ON];
	assign DAC_CODE = q.drive[scan_pkg::CELL_DAC_LSB +: scan_pkg::DAC_BITS];
	assign CHANNEL_BYPASS_SELECT = q.drive[scan_pkg::CELL_CHANNEL_BYPASS_SELECT];
	assign NEGATIVE_GROUND_ENABLE = q.drive[scan_pkg::CELL_NEGATIVE_GROUND_ENABLE];
	assign SAMPLE_HOLD = q.drive[scan_pkg::CELL_SAMPLE_HOLD];
	assign LINK.tdo = q.tdo;

	always_comb
	begin
		d = q;
		d.s1 = from_side;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// A change counts once the second and third stages agree.
		for (int i = 0; i < scan_pkg::CELLS; i++)
		begin
			if (q.s2[i] == q.s3[i])
			begin
				d.filt[i] = q.s3[i];
			end
		end
		if (LINK.capture)
		begin
			d.chain = q.filt;
			if (q.drive[scan_pkg::CELL_COMPARATOR_OFF])
			begin
				d.chain[scan_pkg::CELL_COMPARATOR_RESULT] = 1'b0;
			end
			if (!q.drive[scan_pkg::CELL_CONVERTER_POWER_ON])
			begin
				d.chain[scan_pkg::CELL_CONVERTER_RESULT] = 1'b0;
			end
		end
		else if (LINK.shift)
		begin
			d.chain = {LINK.tdi, q.chain[scan_pkg::CELLS - 1:1]};
		end
		if (LINK.update)
		begin
			d.upd = q.chain;
		end
		d.tdo = d.chain[0];
		for (int i = 0; i < scan_pkg::CELLS; i++)
		begin
			d.drive[i] = LINK.extest ? q.upd[i] : q.filt[i];
		end
		// In external test, grounding and the band-gap must not both drive the negative input.
		if (LINK.extest && q.upd[scan_pkg::CELL_NEGATIVE_GROUND_ENABLE])
		begin
			d.drive[scan_pkg::CELL_CONVERTER_BANDGAP_ENABLE] = 1'b0;
		end
		if (!LINK.link_rst_n)
		begin
			d = '0;
			d.upd = scan_pkg::IDLE_PATTERN;
		end
	end

	always_ff @(posedge LINK.tck)
	begin
		q <= d;
	end
endmodule

`default_nettype wire

// File: tb/scan_link_sva.sv
/*
 * Checker on the scan link: strobe order, shift count and serial loop.
 * Assumes the bench instantiates it beside the link interface.
 */
`default_nettype none

module scan_link_sva
(
	// Link signals
	input wire logic tck,
	input wire logic link_rst_n,
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic extest,
	input wire logic tdi,
	input wire logic tdo
);
	logic [4:0] cnt_q;
	logic first_q;

	default clocking cb @(posedge tck);
	endclocking
	default disable iff (!link_rst_n);

	// Counts shift periods since the last capture and keeps the first bit sent.
	always_ff @(posedge tck)
	begin
		if (!link_rst_n || capture)
			cnt_q <= 5'h00;
		else if (shift)
			cnt_q <= cnt_q + 5'h01;
		if (shift && cnt_q == 5'h00)
			first_q <= tdi;
	end

	strobe_excl_a: assert property (!(capture && shift) && !(shift && update))
		else $error("two link strobes at once");
	capture_shift_a: assert property (capture |=> shift [*8])
		else $error("shift does not follow capture");
	capture_update_a: assert property (capture |-> ##24 update)
		else $error("update not 24 periods after capture");
	shift_count_a: assert property (shift |-> cnt_q < 5'h17)
		else $error("too many shift periods");
	last_shift_a: assert property (shift && cnt_q == 5'h16 |=> update && !shift)
		else $error("no update after last shift");
	update_once_a: assert property (update |=> !update && !shift)
		else $error("update longer than one period");
	lsb_loop_a: assert property (shift && cnt_q == 5'h16 |=> tdo == first_q)
		else $error("first bit in is not out after full chain");
	tdo_quiet_a: assert property (!shift && !capture |=> $stable(tdo))
		else $error("serial output moved outside shift");
	extest_steady_a: assert property (capture || shift |=> $stable(extest))
		else $error("extest changed during a scan");

	scan_c: cover property (capture ##1 shift);
	update_c: cover property (update && extest);
	loop_c: cover property (shift && cnt_q == 5'h16);
endmodule

`default_nettype wire

// File: tb/analog_boundary_scan_cells_tb.sv
/*
 * Bench for the analog scan cells and their controller joined by the link interface.
 * Assumes the design sources and the checker are compiled first.
 */
`default_nettype none

module analog_boundary_scan_cells_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic MCLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [3:0] AWADDR, ARADDR, WSTRB;
	logic [31:0] WDATA, RDATA, rd;
	logic [1:0] BRESP, RRESP, rr;
	logic [22:0] fn_v;
	wire [22:0] out_v;
	int fails, n_compared;
	localparam logic [22:0] p_pat = 23'h35a6c5;
	localparam logic [22:0] q_pat = 23'h1a5c3b;
	localparam logic [22:0] cap_pat = p_pat & ~23'h000012;
	localparam logic [22:0] r_pat = 23'h2000ff;

	scan_link_if link();

	scan_controller scan_controller_i
	(
		.MCLK(MCLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.LINK(link)
	);

	analog_scan_cells analog_scan_cells_i
	(
		.LINK(link), .FN_COMPARATOR_OFF(fn_v[0]), .FN_COMPARATOR_MUX_SOURCE_SELECT(fn_v[2]),
		.FN_COMPARATOR_BANDGAP_ENABLE(fn_v[3]), .FN_AMP_CLOCK(fn_v[5]),
		.FN_AMP_PATH_ENABLE(fn_v[6]), .FN_CONVERTER_BANDGAP_ENABLE(fn_v[7]),
		.FN_CONVERTER_POWER_ON(fn_v[8]), .FN_AMP_POWER_ON(fn_v[9]), .FN_DAC_CODE(fn_v[19:10]),
		.FN_CHANNEL_BYPASS_SELECT(fn_v[20]), .FN_NEGATIVE_GROUND_ENABLE(fn_v[21]),
		.FN_SAMPLE_HOLD(fn_v[22]), .AN_COMPARATOR_RESULT(fn_v[1]),
		.AN_CONVERTER_RESULT(fn_v[4]), .COMPARATOR_OFF(out_v[0]),
		.COMPARATOR_MUX_SOURCE_SELECT(out_v[2]), .COMPARATOR_BANDGAP_ENABLE(out_v[3]),
		.AMP_CLOCK(out_v[5]), .AMP_PATH_ENABLE(out_v[6]), .CONVERTER_BANDGAP_ENABLE(out_v[7]),
		.CONVERTER_POWER_ON(out_v[8]), .AMP_POWER_ON(out_v[9]), .DAC_CODE(out_v[19:10]),
		.CHANNEL_BYPASS_SELECT(out_v[20]), .NEGATIVE_GROUND_ENABLE(out_v[21]),
		.SAMPLE_HOLD(out_v[22]), .COMPARATOR_RESULT(out_v[1]), .CONVERTER_RESULT(out_v[4])
	);

	scan_link_sva scan_link_sva_i
	(
		.tck(link.tck), .link_rst_n(link.link_rst_n), .capture(link.capture),
		.shift(link.shift), .update(link.update), .extest(link.extest), .tdi(link.tdi),
		.tdo(link.tdo)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
		end
	endtask

	// Write: address and data offered together, each released when taken.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er = scan_pkg::RESP_OKAY);
		bit aw;
		bit w;
		aw = 1;
		w = 1;
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (aw || w)
		begin
			@(posedge MCLK);
			if (AWREADY === 1'b1)
				aw = 0;
			if (WREADY === 1'b1)
				w = 0;
			AWVALID <= aw;
			WVALID <= w;
		end
		do
			@(posedge MCLK);
		while (BVALID !== 1'b1);
		BREADY <= 1'b0;
		check(32'(BRESP), 32'(er), "write response");
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
			@(posedge MCLK);
		while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do
			@(posedge MCLK);
		while (RVALID !== 1'b1);
		RREADY <= 1'b0;
		d = RDATA;
		r = RRESP;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
		input logic [1:0] er = scan_pkg::RESP_OKAY);
		axi_rd(a, rd, rr);
		check(rd, exp, "read data");
		check(32'(rr), 32'(er), "read response");
	endtask

	task automatic scan_and_settle();
		axi_wr(scan_pkg::ADDR_STATUS, 32'h2);
		axi_wr(scan_pkg::ADDR_CTRL, 32'h3);
		do
			axi_rd(scan_pkg::ADDR_STATUS, rd, rr);
		while (rd[scan_pkg::STAT_DONE] !== 1'b1);
		repeat (40) @(posedge MCLK);
	endtask

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		MCLK = 1'b0;
		forever
			#5 MCLK = ~MCLK;
	end

	initial
	begin
		#200us;
		fails++;
		test_done();
	end

	initial
	begin
		RSTN = 1'b0;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		{AWADDR, ARADDR} = 8'h00;
		WSTRB = 4'hf;
		WDATA = 32'h0;
		fn_v = 23'h0;
		fails = 0;
		n_compared = 0;
		repeat (20) @(posedge MCLK);
		RSTN <= 1'b1;
		rd_chk(scan_pkg::ADDR_TX, 32'(scan_pkg::IDLE_PATTERN));
		rd_chk(scan_pkg::ADDR_STATUS, 32'h0);
		rd_chk(4'h2, 32'h0, scan_pkg::RESP_SLVERR);
		axi_wr(4'h2, 32'h0, scan_pkg::RESP_SLVERR);
		$display("test reset done");
		fn_v <= p_pat;
		repeat (40) @(posedge MCLK);
		scan_and_settle();
		rd_chk(scan_pkg::ADDR_RX, 32'(cap_pat));
		rd_chk(scan_pkg::ADDR_CTRL, 32'h2);
		check(32'(out_v), 32'(scan_pkg::IDLE_PATTERN), "idle");
		$display("test idle scan done");
		axi_wr(scan_pkg::ADDR_TX, 32'(q_pat));
		scan_and_settle();
		rd_chk(scan_pkg::ADDR_STATUS, 32'h2);
		check(32'(out_v), 32'(q_pat), "loaded");
		axi_wr(scan_pkg::ADDR_RX, 32'h0);
		rd_chk(scan_pkg::ADDR_RX, 32'(cap_pat));
		$display("test load scan done");
		axi_wr(scan_pkg::ADDR_CTRL, 32'h6);
		repeat (12) @(posedge MCLK);
		axi_wr(scan_pkg::ADDR_CTRL, 32'h2);
		repeat (40) @(posedge MCLK);
		check(32'(out_v), 32'(scan_pkg::IDLE_PATTERN), "link reset");
		$display("test link reset done");
		fn_v <= 23'h7fffff;
		repeat (40) @(posedge MCLK);
		axi_wr(scan_pkg::ADDR_TX, 32'(r_pat));
		scan_and_settle();
		rd_chk(scan_pkg::ADDR_RX, 32'h7fffed);
		check(32'(out_v), 32'(r_pat & ~23'h000080), "ground contention");
		fn_v <= p_pat;
		$display("test ground contention done");
		axi_wr(scan_pkg::ADDR_CTRL, 32'h0);
		repeat (40) @(posedge MCLK);
		check(32'(out_v), 32'(p_pat), "functional");
		fn_v <= ~p_pat;
		repeat (40) @(posedge MCLK);
		check(32'(out_v), 32'(p_pat ^ 23'h7fffff), "functional");
		$display("test functional done");
		test_done();
	end
endmodule

`default_nettype wire
